/* rtl/tcp_capture_top.sv */
// Capture channel control registers on APB with four capture channels
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Edge prescaler divides channel edges before capture
// - Prescaler count clears when channel disabled
// - Divider code 00 captures every edge
// - Codes 01/10/11 capture per 2/4/8 edges
// - Control register B at 0x1C, resets zero
// - Filtered level valid after N equal samples
// - Mode selects output, own, neighbour, trigger
// - Mode writable only while channel disabled
module tcp_capture_top (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [tcp_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  input wire logic [tcp_pkg::NUM_CH-1:0] I_CH_IN,
  input wire logic I_ITS,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [tcp_pkg::NUM_CH-1:0] O_CAPTURE,
  output logic [tcp_pkg::NUM_CH-1:0] O_FILT
);

  // ****************************************************************
  // Register layout
  // ****************************************************************
  // Control A at 0x18: channel 0 in bits 7:0
  // Control A: channel 1 in bits 15:8
  // Control B at 0x1C: channel 2 in bits 7:0
  // Control B: channel 3 in bits 15:8
  // Enable register at 0x20: one bit per channel
  // Bits 31:16 of each register read zero
  // Every register resets to zero
  // Per channel byte: bits 1:0 input mode
  // Per channel byte: bits 3:2 edge divider
  // Per channel byte: bits 7:4 input filter
  // Mode 00: output, edges ignored
  // Mode 01: own filtered input
  // Mode 10: paired neighbour's filtered input
  // Mode 11: shared internal trigger level
  // Divider 00/01/10/11: every 1st/2nd/4th/8th edge

  // ****************************************************************
  // Bus timing
  // ****************************************************************
  // Setup cycle: select high, enable low
  // First access edge latches the request
  // Ready and error rise on that same edge
  // Writes land at the ready edge
  // Read data stands until the next read
  // Read strobes are ignored
  // Writes need all four strobes set
  // Unmapped accesses or partial writes flag error
  // Refused writes leave storage untouched
  // Locked mode bits drop without error
  // Back-to-back transfers need no idle cycle

  // ****************************************************************
  // Channel behaviour
  // ****************************************************************
  // Filter, edge detect and divider per unit
  // Divider count clears while channel is off
  // Capture pulse lasts a single clock
  // Mode changes only while channel is off
  // Rising edges only; no polarity select
  // Neighbour pairs: 0 with 1, 2 with 3
  // Trigger level shared by all channels
  // Filtered levels also drive the pins

  // ****************************************************************
  // Reset
  // ****************************************************************
  // Synchronous, active high, one edge enough
  // Channel bytes and enables clear
  // Bus outputs and capture pulses clear
  // Filter and sample counters restart
  // First setup allowed right after release

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] cfg_reg [0:tcp_pkg::NUM_CH-1];
  logic [tcp_pkg::NUM_CH-1:0] ena_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic err_next;
  logic hit_a;
  logic hit_b;
  logic hit_e;
  logic access_ph;
  logic wr_commit;
  logic [tcp_pkg::NUM_CH-1:0] filt_lvl;
  logic [tcp_pkg::NUM_CH-1:0] cap_lvl;

  // Address decode and access phase
  assign hit_a = I_PADDR == tcp_pkg::OFS_CTL_A;
  assign hit_b = I_PADDR == tcp_pkg::OFS_CTL_B;
  assign hit_e = I_PADDR == tcp_pkg::OFS_ENA;
  assign access_ph = I_PSEL & I_PENABLE & ~pready_reg;
  assign wr_commit = I_PSEL & I_PENABLE & pready_reg & I_PWRITE & ~pslverr_reg;

  // Read mux over the mapped registers
  always_comb begin
    rd_next = 32'h00000000;
    if (hit_a) begin
      rd_next = {16'h0000, cfg_reg[1], cfg_reg[0]};
    end else if (hit_b) begin
      rd_next = {16'h0000, cfg_reg[3], cfg_reg[2]};
    end else if (hit_e) begin
      rd_next = {28'h0000000, ena_reg};
    end
  end

  // Error on unmapped address or partial write
  always_comb begin
    err_next = ~(hit_a | hit_b | hit_e);
    if (I_PWRITE && I_PSTRB != tcp_pkg::STRB_FULL) begin
      err_next = 1'b1;
    end
  end

  // Ready pulse one cycle into the access phase
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= access_ph;
    end
  end

  // Error flag valid alongside ready
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= access_ph & err_next;
    end
  end

  // Read data taken on the first access edge
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      prdata_reg <= 32'h00000000;
    end else if (access_ph && !I_PWRITE) begin
      prdata_reg <= rd_next;
    end
  end

  // Channel field writes, mode locked while channel enabled
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      for (int c = 0; c < tcp_pkg::NUM_CH; c++) begin
        cfg_reg[c] <= tcp_pkg::RST_CTL[7:0];
      end
    end else if (wr_commit && (hit_a || hit_b)) begin
      for (int c = 0; c < tcp_pkg::NUM_CH; c++) begin
        if ((c < 2) == hit_a) begin
          cfg_reg[c][7:2] <= I_PWDATA[(c % 2) * 8 + 2 +: 6];
          if (!ena_reg[c]) begin
            cfg_reg[c][1:0] <= I_PWDATA[(c % 2) * 8 +: 2];
          end
        end
      end
    end
  end

  // Channel enable register
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ena_reg <= tcp_pkg::RST_ENA;
    end else if (wr_commit && hit_e) begin
      ena_reg <= I_PWDATA[3:0];
    end
  end

  // ****************************************************************
  // Channel units and input selection
  // ****************************************************************
  for (genvar g = 0; g < tcp_pkg::NUM_CH; g++) begin : g_ch
    tcp_chan_if ch_if();
    logic [1:0] mode;

    assign mode = cfg_reg[g][tcp_pkg::MODE_LSB +: 2];
    assign ch_if.raw = I_CH_IN[g];
    assign ch_if.cfg = cfg_reg[g];
    assign ch_if.enable = ena_reg[g];
    // Source per mode: own, paired neighbour or trigger
    assign ch_if.src_lvl = (mode == tcp_pkg::MODE_OWN) ? filt_lvl[g] :
                           (mode == tcp_pkg::MODE_NEIGHBOUR) ? filt_lvl[g ^ 1] :
                           (mode == tcp_pkg::MODE_TRIGGER) ? I_ITS :
                           1'b0;
    assign filt_lvl[g] = ch_if.filt_lvl;
    assign cap_lvl[g] = ch_if.capture;

    tcp_chan_unit u_unit (
      .i_clk(I_MCLK),
      .i_rst(I_RST),
      .ch(ch_if.unit)
    );
  end

  // Outputs straight from flip-flops
  assign O_PRDATA = prdata_reg;
  assign O_PREADY = pready_reg;
  assign O_PSLVERR = pslverr_reg;
  assign O_CAPTURE = cap_lvl;
  assign O_FILT = filt_lvl;

endmodule : tcp_capture_top
`default_nettype wire

/* rtl/tcp_pkg.sv */
// Shared constants for the timer capture prescaler and channel control block
package tcp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CTL_A = 12'h018;
  localparam logic [11:0] OFS_CTL_B = 12'h01C;
  localparam logic [11:0] OFS_ENA = 12'h020;
  localparam logic [31:0] RST_CTL = 32'h00000000;
  localparam logic [3:0] RST_ENA = 4'h0;
  localparam logic [3:0] STRB_FULL = 4'hF;

  // ****************************************************************
  // Per-channel field layout inside one byte lane
  // ****************************************************************
  localparam int NUM_CH = 4;
  localparam int CH_FIELD_W = 8;
  localparam int MODE_LSB = 0;
  localparam int DIV_LSB = 2;
  localparam int FLT_LSB = 4;
  localparam logic [1:0] DIV_MAX_EXP = 2'h3;

  // ****************************************************************
  // Channel modes
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_OUTPUT = 2'h0,
    MODE_OWN = 2'h1,
    MODE_NEIGHBOUR = 2'h2,
    MODE_TRIGGER = 2'h3
  } tcp_mode_t;

  // ****************************************************************
  // Filter table: sample rate exponent and consecutive sample count
  // ****************************************************************
  localparam int SAMP_CNT_W = 5;
  localparam int FLT_CNT_W = 4;

  function automatic logic [6:0] flt_lookup(input logic [3:0] code);
    logic [6:0] r;
    r = 7'h00;
    unique case (code)
      4'h0: r = {3'h0, 4'h0};
      4'h1: r = {3'h0, 4'h2};
      4'h2: r = {3'h0, 4'h4};
      4'h3: r = {3'h0, 4'h8};
      4'h4: r = {3'h1, 4'h6};
      4'h5: r = {3'h1, 4'h8};
      4'h6: r = {3'h2, 4'h6};
      4'h7: r = {3'h2, 4'h8};
      4'h8: r = {3'h3, 4'h6};
      4'h9: r = {3'h3, 4'h8};
      4'hA: r = {3'h4, 4'h5};
      4'hB: r = {3'h4, 4'h6};
      4'hC: r = {3'h4, 4'h8};
      4'hD: r = {3'h5, 4'h5};
      4'hE: r = {3'h5, 4'h6};
      4'hF: r = {3'h5, 4'h8};
    endcase
    return r;
  endfunction : flt_lookup

endpackage : tcp_pkg

/* rtl/tcp_chan_if.sv */
// Carrier between the register block and one capture channel unit
`timescale 1ns/10ps
`default_nettype none
interface tcp_chan_if;
  logic raw;
  logic [7:0] cfg;
  logic enable;
  logic src_lvl;
  logic filt_lvl;
  logic capture;

  modport ctl (output raw, output cfg, output enable, output src_lvl,
               input filt_lvl, input capture);
  modport unit (input raw, input cfg, input enable, input src_lvl,
                output filt_lvl, output capture);
endinterface : tcp_chan_if
`default_nettype wire

/* rtl/tcp_chan_unit.sv */
// One capture channel: input filter, edge detect and edge prescaler
`timescale 1ns/10ps
`default_nettype none
module tcp_chan_unit (
  input wire logic i_clk,
  input wire logic i_rst,
  tcp_chan_if.unit ch
);

  // ****************************************************************
  // Filter sampling
  // ****************************************************************
  logic [tcp_pkg::SAMP_CNT_W-1:0] samp_cnt_reg;
  logic [tcp_pkg::FLT_CNT_W-1:0] flt_cnt_reg;
  logic [tcp_pkg::FLT_CNT_W-1:0] flt_cnt_next;
  logic filt_reg;
  logic src_d_reg;
  logic [2:0] psc_cnt_reg;
  logic capture_reg;
  logic [6:0] flt_sel;
  logic [2:0] samp_exp;
  logic [tcp_pkg::FLT_CNT_W-1:0] flt_need;
  logic [tcp_pkg::SAMP_CNT_W-1:0] samp_mask;
  logic samp_tick;
  logic edge_seen;
  logic [2:0] psc_limit;
  logic [1:0] div_sel;

  // Decode filter code into rate and count
  assign flt_sel = tcp_pkg::flt_lookup(ch.cfg[tcp_pkg::FLT_LSB +: 4]);
  assign samp_exp = flt_sel[6:4];
  assign flt_need = flt_sel[3:0];
  assign samp_mask = tcp_pkg::SAMP_CNT_W'((1 << samp_exp) - 1);
  assign samp_tick = (samp_cnt_reg & samp_mask) == '0;
  assign flt_cnt_next = flt_cnt_reg + 4'h1;

  // Free running sample-rate divider
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      samp_cnt_reg <= '0;
    end else begin
      samp_cnt_reg <= samp_cnt_reg + 5'h01;
    end
  end

  // Level becomes valid after N equal samples in a row
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      filt_reg <= 1'b0;
      flt_cnt_reg <= '0;
    end else if (flt_need == 4'h0) begin
      filt_reg <= ch.raw;
      flt_cnt_reg <= '0;
    end else if (samp_tick) begin
      if (ch.raw == filt_reg) begin
        flt_cnt_reg <= '0;
      end else if (flt_cnt_next >= flt_need) begin
        filt_reg <= ch.raw;
        flt_cnt_reg <= '0;
      end else begin
        flt_cnt_reg <= flt_cnt_next;
      end
    end
  end

  // ****************************************************************
  // Edge prescaler
  // ****************************************************************
  assign div_sel = ch.cfg[tcp_pkg::DIV_LSB +: 2];
  assign psc_limit = 3'((1 << div_sel) - 1);
  assign edge_seen = ch.src_lvl & ~src_d_reg;

  // Previous source level for rising edge detect
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      src_d_reg <= 1'b0;
    end else begin
      src_d_reg <= ch.src_lvl;
    end
  end

  // Count edges, capture every 1st, 2nd, 4th or 8th
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      psc_cnt_reg <= '0;
      capture_reg <= 1'b0;
    end else if (!ch.enable) begin
      psc_cnt_reg <= '0;
      capture_reg <= 1'b0;
    end else if (edge_seen &&
                 ch.cfg[tcp_pkg::MODE_LSB +: 2] != tcp_pkg::MODE_OUTPUT) begin
      if (psc_cnt_reg >= psc_limit) begin
        psc_cnt_reg <= '0;
        capture_reg <= 1'b1;
      end else begin
        psc_cnt_reg <= psc_cnt_reg + 3'h1;
        capture_reg <= 1'b0;
      end
    end else begin
      capture_reg <= 1'b0;
    end
  end

  assign ch.filt_lvl = filt_reg;
  assign ch.capture = capture_reg;

endmodule : tcp_chan_unit
`default_nettype wire

/* sim/tcp_capture_top_sva.sv */
// Port checker for the capture block
`timescale 1ns/10ps
`default_nettype none
module tcp_capture_sva (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [3:0] I_PSTRB,
  input wire logic I_ITS,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic [3:0] O_CAPTURE,
  input wire logic [3:0] O_FILT
);
  // ****
  // Bus and capture checks
  // ****
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  logic acc;
  // Access phase still waiting
  assign acc = I_PSEL && I_PENABLE && !O_PREADY;
  ready_one_cycle_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("pready longer than one cycle");
  ready_after_access_a: assert property (O_PREADY |-> $past(I_PSEL && I_PENABLE))
    else $error("pready without access");
  access_answer_a: assert property (acc |=> O_PREADY)
    else $error("access not answered");
  strobe_error_a: assert property (acc && I_PWRITE && I_PSTRB != 4'hF |=> O_PSLVERR)
    else $error("partial write not refused");
  unmapped_error_a: assert property
    (acc && !(I_PADDR inside {12'h018, 12'h01C, 12'h020}) |=> O_PSLVERR)
    else $error("unmapped access not refused");
  capture_pulse_a: assert property (|O_CAPTURE |=> (O_CAPTURE & $past(O_CAPTURE)) == 4'h0)
    else $error("capture pulse too long");
  capture_cause_a: assert property (|O_CAPTURE |->
    |($past(O_FILT) & ~$past(O_FILT, 2)) || $past(I_ITS) || $past(I_ITS, 2))
    else $error("capture without source edge");
  reset_quiet_a: assert property ($fell(I_RST) |-> O_CAPTURE == 4'h0 && O_FILT == 4'h0)
    else $error("outputs not cleared by reset");
endmodule : tcp_capture_sva
bind tcp_capture_top tcp_capture_sva tcp_capture_sva_i (.I_MCLK, .I_RST, .I_PSEL, .I_PENABLE,
  .I_PWRITE, .I_PADDR, .I_PSTRB, .I_ITS, .O_PREADY, .O_PSLVERR, .O_CAPTURE, .O_FILT);
`default_nettype wire

/* sim/tcp_capture_top_tb.sv */
// Self-checking bench for the capture block
`timescale 1ns/10ps
`default_nettype none
module tcp_capture_top_tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [3:0] pst = 4'hF;
  logic [4:0] src = 5'h00;
  logic [31:0] prd, rdv;
  logic [3:0] cap, filt;
  logic rdy, err, erv;
  logic [31:0] seed = 32'h0887;
  int n_errors = 0;
  int checks = 0;
  int ncap = 0;
  int ch = 0;
  int ra = 0;
  int rb = 0;
  int en = 0;
  tcp_capture_top tcp_capture_top_i (.I_MCLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .I_PSTRB(pst), .I_CH_IN(src[3:0]),
    .I_ITS(src[4]), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err), .O_CAPTURE(cap),
    .O_FILT(filt));
  // ****
  // Clock, capture counter, helpers
  // ****
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (cap[ch] === 1'h1) ncap++;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // Model of a control write: mode bits kept on enabled channels
  function automatic int mrg(int o, int n, int e);
    int r = n & 32'h0000FFFF;
    for (int k = 0; k < 2; k++) if (e[k]) r[k*8+:2] = o[k*8+:2];
    return r;
  endfunction : mrg
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    pst <= s;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (rdy !== 1'h1) @(posedge clk);
    rdv = prd;
    erv = err;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input int d);
    apb(1'h1, a, d, 4'hF);
    chk(erv, 1'h0, "write error");
    if (a == 12'h018) ra = mrg(ra, d, en);
    if (a == 12'h01C) rb = mrg(rb, d, en >> 2);
    if (a == 12'h020) en = d & 15;
  endtask : wr
  task automatic rd(input logic [11:0] a, input int e);
    apb(1'h0, a, 32'h0, 4'hF);
    chk(rdv, e, "read data");
  endtask : rd
  // Raw pulse on a channel input (index 4 is the trigger)
  task automatic pls(input int b, input int n);
    @(posedge clk);
    src[b] <= 1'h1;
    repeat (n) @(posedge clk);
    src[b] <= 1'h0;
    repeat (6) @(posedge clk);
  endtask : pls
  task automatic print_verdict;
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rd(12'h01C, 0);
    apb(1'h0, 12'h040, 32'h0, 4'hF);
    chk(erv, 1'h1, "unmapped error");
    apb(1'h1, 12'h01C, 32'hFFFF, 4'h3);
    chk(erv, 1'h1, "strobe error");
    rd(12'h01C, 0);
    repeat (4) begin
      seed = xs(seed);
      wr(12'h01C, seed);
      rd(12'h01C, rb);
    end
    wr(12'h018, 32'h01);
    wr(12'h020, 1);
    wr(12'h018, 32'h0E);
    rd(12'h018, ra);
    ch = 2;
    for (int d = 0; d < 4; d++) begin
      wr(12'h020, 0);
      wr(12'h01C, 1 | d << 2);
      wr(12'h020, 4);
      ncap = 0;
      repeat (16) pls(2, 2);
      chk(ncap, 16 >> d, "captures per divider");
    end
    wr(12'h01C, 32'h09);
    ncap = 0;
    repeat (3) pls(2, 2);
    wr(12'h020, 0);
    wr(12'h020, 4);
    repeat (3) pls(2, 2);
    chk(ncap, 0, "captures after disable");
    pls(2, 2);
    chk(ncap, 1, "capture after restart");
    wr(12'h01C, 32'h31);
    ncap = 0;
    pls(2, 3);
    chk(ncap, 0, "short pulse filtered");
    chk(filt[2], 1'h0, "filtered level low");
    pls(2, 12);
    chk(ncap, 1, "long pulse passed");
    chk(filt[2], 1'h1, "filtered level high");
    wr(12'h01C, 32'h41);
    ncap = 0;
    pls(2, 6);
    chk(ncap, 0, "slow filter short pulse");
    pls(2, 16);
    chk(ncap, 1, "slow filter long pulse");
    ch = 0;
    for (int m = 0; m < 4; m++) begin
      wr(12'h020, 0);
      wr(12'h018, m);
      wr(12'h020, 1);
      for (int s = 0; s < 3; s++) begin
        ncap = 0;
        pls(s == 2 ? 4 : s, 2);
        chk(ncap, int'(m == s + 1), "capture per mode");
      end
    end
    print_verdict();
  end
endmodule : tcp_capture_top_tb
`default_nettype wire
